// ---- rtl/sim_mirror.sv ----
/*
 * Sensor geometry and mirroring stage. Takes pixels from one or two zone
 * streams, computes the mirrored column, row and frame bank for each pixel
 * and hands the tagged pixel to the frame-memory writer through a FIFO.
 * Holds the geometry settings and refuses writes that break their limits.
 * Assumes the upstream streams sit on clk_i and mark first pixel and line end.
 *
 */
// The strobed register port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none

module sim_mirror #(
	parameter int PIX_W = 8,
	parameter int FIFO_DEPTH = 4,
	parameter logic [33:0] MAX_FRAME_PIX = sim_pkg::MAX_FRAME_PIX_DEF
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [sim_pkg::ADDR_W-1:0] reg_addr_i,
	input wire logic [sim_pkg::DATA_W-1:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	output logic [sim_pkg::DATA_W-1:0] reg_rdata_o,
	input wire logic s0_valid_i,
	input wire logic [PIX_W-1:0] s0_data_i,
	input wire logic s0_sof_i,
	input wire logic s0_eol_i,
	output logic s0_ready_o,
	input wire logic s1_valid_i,
	input wire logic [PIX_W-1:0] s1_data_i,
	input wire logic s1_sof_i,
	input wire logic s1_eol_i,
	output logic s1_ready_o,
	output logic m_valid_o,
	input wire logic m_ready_i,
	output logic [PIX_W-1:0] m_data_o,
	output logic [sim_pkg::IDX_W-1:0] m_col_o,
	output logic [sim_pkg::IDX_W-1:0] m_row_o,
	output logic m_bank_o,
	output logic m_sof_o,
	output logic [sim_pkg::SZ_W-1:0] eff_line_pixels_o,
	output logic [sim_pkg::SZ_W-1:0] eff_frame_lines_o
);
	localparam int IW = sim_pkg::IDX_W;
	localparam int SW = sim_pkg::SZ_W;
	localparam int WORD_W = PIX_W + 2 * IW + 2;
	localparam int CNT_W = $clog2(FIFO_DEPTH+1);

	// ****************************************************************
	// Helpers
	// ****************************************************************
	function automatic logic in_range(input logic [SW-1:0] v,
		input logic [SW-1:0] lo, input logic [SW-1:0] hi);
		in_range = (v >= lo) && (v <= hi);
	endfunction

	function automatic logic sum_fits(input logic [SW-1:0] a,
		input logic [SW-1:0] b, input logic [SW-1:0] lim);
		sum_fits = ({1'b0, a} + {1'b0, b}) <= {1'b0, lim};
	endfunction

	function automatic logic [IW-1:0] flip_idx(input logic [IW-1:0] idx,
		input logic [SW-1:0] size);
		logic [SW-1:0] t;
		t = size - SW'(1) - {1'b0, idx};
		flip_idx = t[IW-1:0];
	endfunction

	// ****************************************************************
	// Geometry settings
	// ****************************************************************
	sim_pkg::sim_view_t view_reg, view_next, c_view;
	sim_pkg::sim_tap_t tap_reg, tap_next, c_tap;
	logic [SW-1:0] sens_w_reg, sens_w_next, c_sw;
	logic [SW-1:0] sens_h_reg, sens_h_next, c_sh;
	logic [SW-1:0] col_start_reg, col_start_next, c_col;
	logic [SW-1:0] crop_w_reg, crop_w_next, c_cw;
	logic [SW-1:0] row_start_reg, row_start_next, c_row;
	logic [SW-1:0] crop_h_reg, crop_h_next, c_ch;
	logic reject_reg, reject_next;
	logic [sim_pkg::DATA_W-1:0] rdata_reg, rdata_next;
	logic [SW-1:0] eff_w, eff_h, eff_w_reg, eff_h_reg;
	logic h_mir, v_mir, two_zone, c_h, c_v, c_two, hi_zero, accept;
	logic [SW-1:0] wval;
	logic [33:0] frame_pix;
	logic bank_reg, bank_next;

	assign h_mir = view_reg[sim_pkg::VIEW_H_BIT];
	assign v_mir = view_reg[sim_pkg::VIEW_V_BIT];
	assign two_zone = (tap_reg == sim_pkg::two_zone_vertical_layout);
	// Sensor width only counts when columns are reversed
	assign eff_w = h_mir ? sens_w_reg : col_start_reg + crop_w_reg;
	// Sensor height only counts when rows are reversed or zones merged
	assign eff_h = (v_mir || two_zone) ? sens_h_reg
		: row_start_reg + crop_h_reg;

	// Candidate set: current values with the written field replaced
	always_comb begin
		wval = reg_wdata_i[SW-1:0];
		hi_zero = (reg_wdata_i[sim_pkg::DATA_W-1:SW] == '0);
		c_view = view_reg;
		c_tap = tap_reg;
		c_sw = sens_w_reg;
		c_sh = sens_h_reg;
		c_col = col_start_reg;
		c_cw = crop_w_reg;
		c_row = row_start_reg;
		c_ch = crop_h_reg;
		unique case (reg_addr_i)
			sim_pkg::OFS_VIEW: begin
				c_view = sim_pkg::sim_view_t'(reg_wdata_i[1:0]);
				hi_zero = (reg_wdata_i[sim_pkg::DATA_W-1:2] == '0);
			end
			sim_pkg::OFS_TAP: begin
				c_tap = sim_pkg::sim_tap_t'(reg_wdata_i[0]);
				hi_zero = (reg_wdata_i[sim_pkg::DATA_W-1:1] == '0);
			end
			sim_pkg::OFS_SENS_W: c_sw = wval;
			sim_pkg::OFS_SENS_H: c_sh = wval;
			sim_pkg::OFS_COL: c_col = wval;
			sim_pkg::OFS_CROP_W: c_cw = wval;
			sim_pkg::OFS_ROW: c_row = wval;
			sim_pkg::OFS_CROP_H: c_ch = wval;
			default: hi_zero = hi_zero;
		endcase
		c_h = c_view[sim_pkg::VIEW_H_BIT];
		c_v = c_view[sim_pkg::VIEW_V_BIT];
		c_two = (c_tap == sim_pkg::two_zone_vertical_layout);
		frame_pix = 34'(c_sw) * 34'(c_sh);
		// Whole candidate set must hold, else the write is refused
		accept = hi_zero
			&& in_range(c_sw, sim_pkg::SENS_W_MIN, sim_pkg::SENS_W_MAX)
			&& (c_sw[sim_pkg::STEP_BITS-1:0] == '0)
			&& in_range(c_sh, sim_pkg::SENS_H_MIN, sim_pkg::SENS_H_MAX)
			&& in_range(c_cw, sim_pkg::SENS_W_MIN, sim_pkg::SENS_W_MAX)
			&& (c_cw[sim_pkg::STEP_BITS-1:0] == '0)
			&& (c_col[sim_pkg::STEP_BITS-1:0] == '0)
			&& in_range(c_ch, sim_pkg::SENS_H_MIN, sim_pkg::SENS_H_MAX)
			&& sum_fits(c_col, c_cw, sim_pkg::SENS_W_MAX)
			&& sum_fits(c_row, c_ch, sim_pkg::SENS_H_MAX)
			&& (!c_h || sum_fits(c_col, c_cw, c_sw))
			&& (!(c_v || c_two) || sum_fits(c_row, c_ch, c_sh))
			&& (!c_two || !c_sh[0])
			&& (!c_v || (frame_pix <= MAX_FRAME_PIX));
	end

	// Write handling and read data, one cycle after the read strobe
	always_comb begin
		view_next = view_reg;
		tap_next = tap_reg;
		sens_w_next = sens_w_reg;
		sens_h_next = sens_h_reg;
		col_start_next = col_start_reg;
		crop_w_next = crop_w_reg;
		row_start_next = row_start_reg;
		crop_h_next = crop_h_reg;
		reject_next = reject_reg;
		rdata_next = '0;
		if (reg_wr_i && reg_addr_i <= sim_pkg::OFS_CROP_H
			&& reg_addr_i[1:0] == 2'h0) begin
			reject_next = !accept;
			if (accept) begin
				view_next = c_view;
				tap_next = c_tap;
				sens_w_next = c_sw;
				sens_h_next = c_sh;
				col_start_next = c_col;
				crop_w_next = c_cw;
				row_start_next = c_row;
				crop_h_next = c_ch;
			end
		end
		if (reg_rd_i) begin
			unique case (reg_addr_i)
				sim_pkg::OFS_VIEW: rdata_next = 32'(view_reg);
				sim_pkg::OFS_TAP: rdata_next = 32'(tap_reg);
				sim_pkg::OFS_SENS_W: rdata_next = 32'(sens_w_reg);
				sim_pkg::OFS_SENS_H: rdata_next = 32'(sens_h_reg);
				sim_pkg::OFS_COL: rdata_next = 32'(col_start_reg);
				sim_pkg::OFS_CROP_W: rdata_next = 32'(crop_w_reg);
				sim_pkg::OFS_ROW: rdata_next = 32'(row_start_reg);
				sim_pkg::OFS_CROP_H: rdata_next = 32'(crop_h_reg);
				sim_pkg::OFS_STATUS: begin
					rdata_next[sim_pkg::ST_REJECT_BIT] = reject_reg;
					rdata_next[sim_pkg::ST_BANK_BIT] = bank_reg;
				end
				sim_pkg::OFS_EFF_W: rdata_next = 32'(eff_w_reg);
				sim_pkg::OFS_EFF_H: rdata_next = 32'(eff_h_reg);
				default: rdata_next = '0;
			endcase
		end
	end

	// Settings registers
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			view_reg <= sim_pkg::view_upper_left;
			tap_reg <= sim_pkg::single_zone_layout;
			sens_w_reg <= sim_pkg::RST_SENS_W;
			sens_h_reg <= sim_pkg::RST_SENS_H;
			col_start_reg <= sim_pkg::RST_OFS;
			crop_w_reg <= sim_pkg::RST_CROP_W;
			row_start_reg <= sim_pkg::RST_OFS;
			crop_h_reg <= sim_pkg::RST_CROP_H;
			reject_reg <= 1'b0;
			rdata_reg <= '0;
			eff_w_reg <= sim_pkg::RST_SENS_W;
			eff_h_reg <= sim_pkg::RST_SENS_H;
		end else begin
			view_reg <= view_next;
			tap_reg <= tap_next;
			sens_w_reg <= sens_w_next;
			sens_h_reg <= sens_h_next;
			col_start_reg <= col_start_next;
			crop_w_reg <= crop_w_next;
			row_start_reg <= row_start_next;
			crop_h_reg <= crop_h_next;
			reject_reg <= reject_next;
			rdata_reg <= rdata_next;
			eff_w_reg <= eff_w;
			eff_h_reg <= eff_h;
		end
	end

	// ****************************************************************
	// Pixel path
	// ****************************************************************
	logic [IW-1:0] col_pos_reg [2];
	logic [IW-1:0] col_pos_next [2];
	logic [IW-1:0] line_pos_reg [2];
	logic [IW-1:0] line_pos_next [2];
	sim_pkg::sim_turn_t turn_reg, turn_next;
	logic s0_ready_reg, s0_ready_next, s1_ready_reg, s1_ready_next;
	logic take0, take1, push, zone, sof, eol, fifo_in_ready;
	logic [PIX_W-1:0] pix;
	logic [IW-1:0] cur_col, cur_line, row_raw, row_out, col_out;
	logic [WORD_W-1:0] word, fifo_word;
	logic [CNT_W-1:0] fifo_cnt;

	// Merge zones one beat at a time; full crop is applied downstream
	always_comb begin
		take0 = s0_ready_reg & s0_valid_i & fifo_in_ready;
		take1 = s1_ready_reg & s1_valid_i & fifo_in_ready;
		push = take0 | take1;
		zone = take1;
		pix = take1 ? s1_data_i : s0_data_i;
		sof = take1 ? s1_sof_i : s0_sof_i;
		eol = take1 ? s1_eol_i : s0_eol_i;
		cur_col = sof ? '0 : col_pos_reg[zone];
		cur_line = sof ? '0 : line_pos_reg[zone];
		// Second zone is read out from the bottom line upward
		row_raw = (two_zone && zone) ? flip_idx(cur_line, sens_h_reg)
			: cur_line;
		row_out = v_mir ? flip_idx(row_raw, eff_h) : row_raw;
		col_out = h_mir ? flip_idx(cur_col, eff_w) : cur_col;
		// New frame goes to the other half of frame memory only when rows are reversed
		bank_next = bank_reg ^ (take0 & s0_sof_i & v_mir);
		word = {bank_next, sof, row_out, col_out, pix};
		for (int s = 0; s < 2; s++) begin
			col_pos_next[s] = col_pos_reg[s];
			line_pos_next[s] = line_pos_reg[s];
		end
		if (push) begin
			col_pos_next[zone] = eol ? '0 : cur_col + IW'(1);
			line_pos_next[zone] = eol ? cur_line + IW'(1) : cur_line;
		end
		turn_next = sim_pkg::turn_zone0;
		if (two_zone) begin
			turn_next = push ? sim_sel_flip(turn_reg) : turn_reg;
		end
		// Ready only while a slot is sure to be free next cycle
		s0_ready_next = (({1'b0, fifo_cnt} + (CNT_W+1)'(push))
			< (CNT_W+1)'(FIFO_DEPTH)) && (turn_next == sim_pkg::turn_zone0);
		s1_ready_next = (({1'b0, fifo_cnt} + (CNT_W+1)'(push))
			< (CNT_W+1)'(FIFO_DEPTH)) && (turn_next == sim_pkg::turn_zone1);
	end

	function automatic sim_pkg::sim_turn_t sim_sel_flip(
		input sim_pkg::sim_turn_t t);
		sim_sel_flip = (t == sim_pkg::turn_zone0) ? sim_pkg::turn_zone1
			: sim_pkg::turn_zone0;
	endfunction

	// Pixel path registers
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			for (int s = 0; s < 2; s++) begin
				col_pos_reg[s] <= '0;
				line_pos_reg[s] <= '0;
			end
			turn_reg <= sim_pkg::turn_zone0;
			bank_reg <= 1'b0;
			s0_ready_reg <= 1'b0;
			s1_ready_reg <= 1'b0;
		end else begin
			for (int s = 0; s < 2; s++) begin
				col_pos_reg[s] <= col_pos_next[s];
				line_pos_reg[s] <= line_pos_next[s];
			end
			turn_reg <= turn_next;
			bank_reg <= bank_next;
			s0_ready_reg <= s0_ready_next;
			s1_ready_reg <= s1_ready_next;
		end
	end

	// Output buffer toward the frame-memory writer
	sim_fifo #(
		.WIDTH(WORD_W),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.in_valid_i(push),
		.in_data_i(word),
		.in_ready_o(fifo_in_ready),
		.out_valid_o(m_valid_o),
		.out_data_o(fifo_word),
		.out_ready_i(m_ready_i),
		.count_o(fifo_cnt)
	);

	// Outputs are slices of registers
	assign {m_bank_o, m_sof_o, m_row_o, m_col_o, m_data_o} = fifo_word;
	assign s0_ready_o = s0_ready_reg;
	assign s1_ready_o = s1_ready_reg;
	assign reg_rdata_o = rdata_reg;
	assign eff_line_pixels_o = eff_w_reg;
	assign eff_frame_lines_o = eff_h_reg;

endmodule // sim_mirror

`default_nettype wire

// ---- rtl/sim_pkg.sv ----
/*
 * Constants and types for the sensor image mirroring stage: register
 * offsets, field positions, reset values, value limits and enumerations.
 * Assumes a 32-bit register port with byte offsets on an 8-bit address.
 */
package sim_pkg;

	// ****************************************************************
	// Register map
	// ****************************************************************
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam logic [7:0] OFS_VIEW = 8'h00;
	localparam logic [7:0] OFS_TAP = 8'h04;
	localparam logic [7:0] OFS_SENS_W = 8'h08;
	localparam logic [7:0] OFS_SENS_H = 8'h0c;
	localparam logic [7:0] OFS_COL = 8'h10;
	localparam logic [7:0] OFS_CROP_W = 8'h14;
	localparam logic [7:0] OFS_ROW = 8'h18;
	localparam logic [7:0] OFS_CROP_H = 8'h1c;
	localparam logic [7:0] OFS_STATUS = 8'h20;
	localparam logic [7:0] OFS_EFF_W = 8'h24;
	localparam logic [7:0] OFS_EFF_H = 8'h28;

	// ****************************************************************
	// Field layout
	// ****************************************************************
	localparam int SZ_W = 17;
	localparam int IDX_W = 16;
	localparam int VIEW_H_BIT = 0;
	localparam int VIEW_V_BIT = 1;
	localparam int ST_REJECT_BIT = 0;
	localparam int ST_BANK_BIT = 1;
	localparam int STEP_BITS = 5;

	// ****************************************************************
	// Limits and reset values
	// ****************************************************************
	localparam logic [16:0] SENS_W_MIN = 17'h00040;
	localparam logic [16:0] SENS_W_MAX = 17'h08000;
	localparam logic [16:0] SENS_H_MIN = 17'h00002;
	localparam logic [16:0] SENS_H_MAX = 17'h10000;
	localparam logic [16:0] RST_SENS_W = 17'h00400;
	localparam logic [16:0] RST_SENS_H = 17'h00400;
	localparam logic [16:0] RST_CROP_W = 17'h00400;
	localparam logic [16:0] RST_CROP_H = 17'h00400;
	localparam logic [16:0] RST_OFS = 17'h00000;
	localparam logic [33:0] MAX_FRAME_PIX_DEF = 34'h004000000;

	// ****************************************************************
	// Enumerations
	// ****************************************************************
	typedef enum logic [1:0] {
		view_upper_left = 2'b00,
		view_upper_right = 2'b01,
		view_lower_left = 2'b10,
		view_lower_right = 2'b11
	} sim_view_t;

	typedef enum logic {
		single_zone_layout = 1'b0,
		two_zone_vertical_layout = 1'b1
	} sim_tap_t;

	typedef enum logic {
		turn_zone0 = 1'b0,
		turn_zone1 = 1'b1
	} sim_turn_t;

endpackage

// ---- rtl/sim_fifo.sv ----
/*
 * Small synchronous FIFO with a registered output word.
 * Assumes one clock, synchronous active-high reset, DEPTH of at least 2.
 */
`timescale 1ns/1ps
`default_nettype none

module sim_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 4
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic in_valid_i,
	input wire logic [WIDTH-1:0] in_data_i,
	output logic in_ready_o,
	output logic out_valid_o,
	output logic [WIDTH-1:0] out_data_o,
	input wire logic out_ready_i,
	output logic [$clog2(DEPTH+1)-1:0] count_o
);
	localparam int PTR_W = $clog2(DEPTH);
	localparam int CNT_W = $clog2(DEPTH+1);
	localparam logic [CNT_W-1:0] CNT_ONE = CNT_W'(1);
	localparam logic [CNT_W-1:0] CNT_FULL = CNT_W'(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [PTR_W-1:0] wr_ptr_reg, wr_ptr_next, rd_ptr_reg, rd_ptr_next;
	logic [CNT_W-1:0] mem_cnt_reg, mem_cnt_next;
	logic out_valid_reg, out_valid_next;
	logic [WIDTH-1:0] out_data_reg, out_data_next;
	logic mem_we, mem_rd, push, pop;

	function automatic logic [PTR_W-1:0] ptr_inc(input logic [PTR_W-1:0] p);
		ptr_inc = (p == PTR_W'(DEPTH-1)) ? '0 : p + PTR_W'(1);
	endfunction

	// Output word counts as one slot, so capacity is DEPTH in all
	assign count_o = mem_cnt_reg + CNT_W'(out_valid_reg);
	assign in_ready_o = count_o < CNT_FULL;
	assign out_valid_o = out_valid_reg;
	assign out_data_o = out_data_reg;

	// Next state: refill output register, bypass when memory is empty
	always_comb begin
		push = in_valid_i & in_ready_o;
		pop = out_valid_reg & out_ready_i;
		mem_we = 1'b0;
		mem_rd = 1'b0;
		out_valid_next = out_valid_reg;
		out_data_next = out_data_reg;
		if (!out_valid_reg || pop) begin
			if (mem_cnt_reg != '0) begin
				mem_rd = 1'b1;
				out_valid_next = 1'b1;
				out_data_next = mem[rd_ptr_reg];
				mem_we = push;
			end else begin
				out_valid_next = push;
				if (push) begin
					out_data_next = in_data_i;
				end
			end
		end else begin
			mem_we = push;
		end
		wr_ptr_next = mem_we ? ptr_inc(wr_ptr_reg) : wr_ptr_reg;
		rd_ptr_next = mem_rd ? ptr_inc(rd_ptr_reg) : rd_ptr_reg;
		mem_cnt_next = mem_cnt_reg;
		if (mem_we && !mem_rd) begin
			mem_cnt_next = mem_cnt_reg + CNT_ONE;
		end else if (!mem_we && mem_rd) begin
			mem_cnt_next = mem_cnt_reg - CNT_ONE;
		end
	end

	// Storage has no reset; pointers guard stale words
	always_ff @(posedge clk_i) begin
		if (mem_we) begin
			mem[wr_ptr_reg] <= in_data_i;
		end
	end

	// State registers
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			mem_cnt_reg <= '0;
			out_valid_reg <= 1'b0;
			out_data_reg <= '0;
		end else begin
			wr_ptr_reg <= wr_ptr_next;
			rd_ptr_reg <= rd_ptr_next;
			mem_cnt_reg <= mem_cnt_next;
			out_valid_reg <= out_valid_next;
			out_data_reg <= out_data_next;
		end
	end

endmodule // sim_fifo

`default_nettype wire

// ---- verification/sim_mirror_checker.sv ----
/* Port assertions for the mirroring stage, bound into sim_mirror.
   Assumes one clock and a synchronous active-high reset. */
`timescale 1ns/1ps
`default_nettype none

module sim_mirror_checker #(
	parameter int PIX_W = 8
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [7:0] reg_addr_i,
	input wire logic reg_rd_i,
	input wire logic [31:0] reg_rdata_o,
	input wire logic s0_valid_i,
	input wire logic s0_ready_o,
	input wire logic s1_valid_i,
	input wire logic s1_ready_o,
	input wire logic m_valid_o,
	input wire logic m_ready_i,
	input wire logic [PIX_W-1:0] m_data_o,
	input wire logic [15:0] m_col_o,
	input wire logic [15:0] m_row_o,
	input wire logic [16:0] eff_line_pixels_o,
	input wire logic [16:0] eff_frame_lines_o
);
	default clocking @(posedge clk_i);
	endclocking
	default disable iff (rst_i);
	logic zone_reg;
	logic zone_next;
	logic rd_w;
	logic rd_h;

	// ****************************************************************
	// Helper state
	// ****************************************************************
	// Zone of the last taken beat; starts as zone 1 so zone 0 leads
	always_comb begin
		zone_next = zone_reg;
		if (s0_valid_i && s0_ready_o)
			zone_next = 1'b0;
		if (s1_valid_i && s1_ready_o)
			zone_next = 1'b1;
	end
	always_ff @(posedge clk_i) begin
		if (rst_i)
			zone_reg <= 1'b1;
		else
			zone_reg <= zone_next;
	end
	// Reads of the two size registers
	assign rd_w = reg_rd_i && reg_addr_i == sim_pkg::OFS_SENS_W;
	assign rd_h = reg_rd_i && reg_addr_i == sim_pkg::OFS_SENS_H;

	AST_RST_VAL: assert property ($fell(rst_i) |-> !s0_ready_o &&
		!m_valid_o && eff_frame_lines_o == 17'h00400 &&
		eff_line_pixels_o == 17'h00400) else $error("bad reset values");
	AST_VIEW: assert property (reg_rd_i && reg_addr_i == sim_pkg::OFS_VIEW
		|=> reg_rdata_o[31:2] == 30'h0) else $error("viewpoint too wide");
	AST_SENS_W: assert property (rd_w |=> reg_rdata_o[4:0] == 5'h00 &&
		reg_rdata_o >= 32'h40 && reg_rdata_o <= 32'h8000)
		else $error("sensor width off grid");
	AST_SENS_H: assert property (rd_h |=> reg_rdata_o >= 32'h2 &&
		reg_rdata_o <= 32'h10000) else $error("sensor height off range");
	AST_COL: assert property (m_valid_o |-> m_col_o < eff_line_pixels_o)
		else $error("column beyond line");
	AST_ROW: assert property (m_valid_o |-> m_row_o < eff_frame_lines_o)
		else $error("row beyond frame");
	AST_HOLD: assert property (m_valid_o && !m_ready_i |=> m_valid_o &&
		$stable(m_data_o) && $stable(m_col_o) && $stable(m_row_o))
		else $error("word changed while stalled");
	AST_ZONE: assert property (s1_valid_i && s1_ready_o |-> !zone_reg)
		else $error("zone beats out of turn");
endmodule // sim_mirror_checker

bind sim_mirror sim_mirror_checker #(.PIX_W(PIX_W)) u_chk (
	.clk_i(clk_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i),
	.reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
	.s0_valid_i(s0_valid_i), .s0_ready_o(s0_ready_o),
	.s1_valid_i(s1_valid_i), .s1_ready_o(s1_ready_o),
	.m_valid_o(m_valid_o), .m_ready_i(m_ready_i), .m_data_o(m_data_o),
	.m_col_o(m_col_o), .m_row_o(m_row_o),
	.eff_line_pixels_o(eff_line_pixels_o),
	.eff_frame_lines_o(eff_frame_lines_o)
);

`default_nettype wire

// ---- verification/sim_cam_model.sv ----
/* Camera-side source of zone pixel beats, 3 pixels by 2 lines a zone.
   Assumes ready is registered, so it is sampled at falling edges. */
`timescale 1ns/1ps
`default_nettype none

module sim_cam_model (
	input wire logic clk_i,
	input wire logic go_i,
	input wire logic two_i,
	input wire logic slow_i,
	input wire logic [1:0] ready_i,
	output logic [1:0] valid_o,
	output logic [15:0] data_o,
	output logic [1:0] sof_o,
	output logic [1:0] eol_o
);
	int k;

	// ****************************************************************
	// Beat sender
	// ****************************************************************
	// Holds the beat until ready is seen; bounded so a stuck port ends
	task automatic beat(input int z, input int c, input int l, input bit last);
		if (slow_i)
			repeat (2) @(posedge clk_i);
		valid_o[z] <= 1'b1;
		data_o[z*8 +: 8] <= k[7:0];
		sof_o[z] <= (c == 0 && l == 0);
		eol_o[z] <= (c == 2);
		@(negedge clk_i);
		for (int t = 0; t < 1000 && !ready_i[z]; t++)
			@(negedge clk_i);
		@(posedge clk_i);
		k++;
		// Released lane shows inverted data, not a stale copy
		if (slow_i || two_i || last) begin
			valid_o[z] <= 1'b0;
			data_o[z*8 +: 8] <= ~data_o[z*8 +: 8];
		end
	endtask

	// Frame in raster order, zones interleaved one beat each
	initial begin
		valid_o = 2'b00;
		data_o = 16'h0000;
		sof_o = 2'b00;
		eol_o = 2'b00;
		forever begin
			@(posedge clk_i);
			if (go_i) begin
				k = 0;
				for (int l = 0; l < 2; l++)
					for (int c = 0; c < 3; c++)
						for (int z = 0; z <= int'(two_i); z++)
							beat(z, c, l, l == 1 && c == 2 && z == int'(two_i));
			end
		end
	end
endmodule // sim_cam_model

`default_nettype wire

// ---- verification/testbench.sv ----
/* Self-checking bench for the mirroring stage with a camera model.
   Assumes the package register map; settings change only when idle. */
`timescale 1ns/1ps
`default_nettype none

`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin \
	n_mismatch++; $display("Error %0t: got %h want %h", $time, a, e); end end

module testbench;
	logic clk, rst, wr_s, rd_s, go, slow, m_rdy, bank;
	logic [7:0] addr;
	logic [31:0] wdata, rdata;
	logic [1:0] vld, sof, eol;
	logic [15:0] dat, m_col, m_row;
	logic rdy0, rdy1, m_valid, m_bank, m_sof;
	logic [7:0] m_data;
	logic [16:0] eff_w, eff_h;
	logic [41:0] got[$];
	int n_mismatch = 0;
	int total_checks = 0;

	// Small frame store so the two-frame limit is reachable
	sim_mirror #(.PIX_W(8), .FIFO_DEPTH(4), .MAX_FRAME_PIX(34'h000100000)) dut (
		.clk_i(clk), .rst_i(rst), .reg_addr_i(addr), .reg_wdata_i(wdata),
		.reg_wr_i(wr_s), .reg_rd_i(rd_s), .reg_rdata_o(rdata),
		.s0_valid_i(vld[0]), .s0_data_i(dat[7:0]), .s0_sof_i(sof[0]),
		.s0_eol_i(eol[0]), .s0_ready_o(rdy0), .s1_valid_i(vld[1]),
		.s1_data_i(dat[15:8]), .s1_sof_i(sof[1]), .s1_eol_i(eol[1]),
		.s1_ready_o(rdy1), .m_valid_o(m_valid), .m_ready_i(m_rdy),
		.m_data_o(m_data), .m_col_o(m_col), .m_row_o(m_row),
		.m_bank_o(m_bank), .m_sof_o(m_sof), .eff_line_pixels_o(eff_w),
		.eff_frame_lines_o(eff_h));
	sim_cam_model cam (.clk_i(clk), .go_i(go), .two_i(wdata[0]),
		.slow_i(slow), .ready_i({rdy1, rdy0}), .valid_o(vld), .data_o(dat),
		.sof_o(sof), .eol_o(eol));

	always #2.5 clk = ~clk;
	// Output words as taken by the sink
	always @(posedge clk)
		if (!rst && m_valid && m_rdy)
			got.push_back({m_data, m_col, m_row, m_bank, m_sof});

	// ****************************************************************
	// Register port tasks
	// ****************************************************************
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr_s <= 1'b1;
		@(posedge clk);
		wr_s <= 1'b0;
	endtask
	task automatic rc(input logic [7:0] a, input logic [31:0] e);
		@(posedge clk);
		addr <= a;
		rd_s <= 1'b1;
		@(posedge clk);
		rd_s <= 1'b0;
		@(negedge clk);
		`CHK(rdata, e)
	endtask
	// Write, then judge the reject flag
	task automatic wc(input logic [7:0] a, input logic [31:0] d, input bit r);
		wr(a, d);
		rc(sim_pkg::OFS_STATUS, {30'h0, bank, r});
	endtask

	task automatic results();
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	// One frame; stall holds the sink off until the buffer refuses
	task automatic run(input logic [1:0] v, input bit two, input bit stall);
		int n, z, c, l, r;
		logic [41:0] w;
		n = 6 * (1 + int'(two));
		got.delete();
		wr(sim_pkg::OFS_VIEW, {30'h0, v});
		wr(sim_pkg::OFS_TAP, {31'h0, two});
		if (v[1])
			bank = ~bank;
		go <= 1'b1;
		slow <= stall;
		m_rdy <= !stall;
		@(posedge clk);
		go <= 1'b0;
		if (stall) begin
			repeat (29) @(posedge clk);
			@(negedge clk);
			`CHK(rdy0, 1'b0)
			@(posedge clk);
		end
		m_rdy <= 1'b1;
		for (int i = 0; i < 300 && got.size() < n; i++)
			@(posedge clk);
		@(negedge clk);
		`CHK(got.size(), n)
		if (got.size() < n)
			results();
		for (int i = 0; i < n; i++) begin
			z = two ? i % 2 : 0;
			c = (two ? i / 2 : i) % 3;
			l = (two ? i / 2 : i) / 3;
			r = z ? 3 - l : l;
			w = got[i];
			`CHK(w[41:34], i[7:0])
			`CHK(w[33:18], v[0] ? 16'(63 - c) : 16'(c))
			`CHK(w[17:2], v[1] ? 16'((two ? 3 : 1) - r) : 16'(r))
			`CHK(w[1], bank)
			if (z == 0)
				`CHK(w[0], i == 0)
		end
	endtask

	// ****************************************************************
	// Scenarios
	// ****************************************************************
	task automatic t_reset();
		rc(sim_pkg::OFS_VIEW, 32'h0);
		rc(sim_pkg::OFS_SENS_W, 32'h400);
		rc(sim_pkg::OFS_SENS_H, 32'h400);
		rc(sim_pkg::OFS_EFF_W, 32'h400);
		rc(8'h3c, 32'h0);
	endtask
	task automatic t_width();
		wc(sim_pkg::OFS_SENS_W, 32'h41, 1'b1);
		wc(sim_pkg::OFS_SENS_W, 32'h8020, 1'b1);
		wc(sim_pkg::OFS_SENS_W, 32'h20, 1'b1);
		wc(sim_pkg::OFS_SENS_W, 32'h8000, 1'b0);
		wc(sim_pkg::OFS_SENS_W, 32'h40, 1'b0);
		wc(sim_pkg::OFS_COL, 32'h20, 1'b0);
		`CHK(eff_w, 17'h00420)
		wc(sim_pkg::OFS_VIEW, 32'h1, 1'b1);
		rc(sim_pkg::OFS_VIEW, 32'h0);
		wc(sim_pkg::OFS_SENS_W, 32'h440, 1'b0);
		wc(sim_pkg::OFS_VIEW, 32'h1, 1'b0);
		`CHK(eff_w, 17'h00440)
		wc(sim_pkg::OFS_COL, 32'h60, 1'b1);
		wc(sim_pkg::OFS_COL, 32'h40, 1'b0);
	endtask
	task automatic t_height();
		wr(sim_pkg::OFS_VIEW, 32'h0);
		// Width back to 1024 so 1024 lines exactly fill the frame store
		wc(sim_pkg::OFS_SENS_W, 32'h400, 1'b0);
		wc(sim_pkg::OFS_SENS_H, 32'h1, 1'b1);
		wc(sim_pkg::OFS_SENS_H, 32'h10001, 1'b1);
		wc(sim_pkg::OFS_SENS_H, 32'h10000, 1'b0);
		wc(sim_pkg::OFS_SENS_H, 32'h3ff, 1'b0);
		`CHK(eff_h, 17'h00400)
		wc(sim_pkg::OFS_VIEW, 32'h2, 1'b1);
		wc(sim_pkg::OFS_SENS_H, 32'h401, 1'b0);
		wc(sim_pkg::OFS_TAP, 32'h1, 1'b1);
		wc(sim_pkg::OFS_SENS_H, 32'h400, 1'b0);
		wc(sim_pkg::OFS_VIEW, 32'h2, 1'b0);
		wc(sim_pkg::OFS_ROW, 32'h1, 1'b1);
		wc(sim_pkg::OFS_SENS_H, 32'h402, 1'b1);
		wc(sim_pkg::OFS_VIEW, 32'h0, 1'b0);
		wc(sim_pkg::OFS_SENS_H, 32'h402, 1'b0);
		wc(sim_pkg::OFS_TAP, 32'h1, 1'b0);
		`CHK(eff_h, 17'h00402)
	endtask
	task automatic t_frames();
		wr(sim_pkg::OFS_TAP, 32'h0);
		wr(sim_pkg::OFS_COL, 32'h0);
		wr(sim_pkg::OFS_CROP_W, 32'h40);
		wr(sim_pkg::OFS_SENS_W, 32'h40);
		wr(sim_pkg::OFS_CROP_H, 32'h2);
		// Height is the exact line count the model sends per frame
		wc(sim_pkg::OFS_SENS_H, 32'h2, 1'b0);
		for (int v = 0; v < 4; v++)
			run(v[1:0], 1'b0, v == 2);
		wr(sim_pkg::OFS_SENS_H, 32'h4);
		run(2'h0, 1'b1, 1'b0);
		run(2'h3, 1'b1, 1'b1);
	endtask

	initial begin
		clk = 1'b0;
		rst = 1'b1;
		{addr, wdata, wr_s, rd_s, go, slow, m_rdy, bank} = '0;
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		t_reset();
		t_width();
		t_height();
		t_frames();
		wr(sim_pkg::OFS_VIEW, 32'h3);
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		bank = 1'b0;
		rc(sim_pkg::OFS_VIEW, 32'h0);
		results();
	end
endmodule // testbench

`default_nettype wire
